// ===== wdtml_pkg.sv
// Purpose: Shared constants and types for the watchdog with locked mode register
// Assumes: 200 MHz system clock, 8-bit register port with bank select
// Notes:   Every offset, field position, reset value and timing count but the RC divide ratio lives here
package wdtml_pkg;

  // Register decode
  localparam logic [3:0] BANK_WDT    = 4'hf;   // Expanded bank holding the block
  localparam logic [7:0] ADDR_MODE   = 8'h0f;  // watchdog_mode_control, write only
  localparam logic [7:0] ADDR_STATUS = 8'h0b;  // Read-only status of the block

  // watchdog_mode_control fields
  localparam logic [3:0] MODE_RST      = 4'h0; // Value after any qualifying reset
  localparam int         MODE_TSEL_LSB = 0;    // Timeout select, two bits
  localparam int         MODE_HALT_BIT = 2;    // Keep counting in HALT
  localparam int         MODE_STOP_BIT = 3;    // Keep counting in Stop
  localparam int         MODE_WIDTH    = 4;    // Bits that are stored

  // Status register fields
  localparam int STAT_RUN_BIT = 0;             // Watchdog running
  localparam int STAT_WIN_BIT = 1;             // Mode write window open
  localparam int STAT_WDR_BIT = 2;             // Last reset came from a timeout

  // Write window length
  localparam int WIN_CPU_CYCLES  = 60;         // Processor cycles
  localparam int WIN_XTAL_CLOCKS = 120;        // Same span in crystal clocks

  // Reset one-shot after a timeout
  localparam int CLK_PERIOD_PS = 5000;         // 200 MHz system clock
  localparam int POR_TIME_US   = 2500;         // 2.5 ms least
  localparam int POR_CYCLES    =
    (POR_TIME_US * 1000 + CLK_PERIOD_PS / 1000 - 1) / (CLK_PERIOD_PS / 1000);

  // Restart address after a watchdog reset
  localparam logic [15:0] RESTART_VECTOR = 16'h000c;

  // Counter taps for the four timeout codes, longer for larger codes
  localparam int TAP0 = 9;
  localparam int TAP1 = 11;
  localparam int TAP2 = 13;
  localparam int TAP3 = 15;

  // Flag values written by the refresh instruction
  localparam logic FLAG_Z_VAL = 1'b0;
  localparam logic FLAG_S_VAL = 1'b0;
  localparam logic FLAG_V_VAL = 1'b0;

  // Write window states
  typedef enum logic [2:0] {
    WIN_WAIT = 3'b001,                         // Waiting for first instruction
    WIN_OPEN = 3'b010,                         // Writes accepted
    WIN_LOCK = 3'b100                          // Writes ignored
  } wdtml_win_type;

  // Tap index for a timeout select code
  function automatic int tap_index(input logic [1:0] tsel);
    int idx;
    idx = TAP0;
    case (tsel)
      2'h0:    idx = TAP0;
      2'h1:    idx = TAP1;
      2'h2:    idx = TAP2;
      2'h3:    idx = TAP3;
      default: idx = TAP0;
    endcase
    return idx;
  endfunction

endpackage

// ===== wdtml_watchdog.sv
// Purpose: Retriggerable watchdog with a mode register that locks after boot
// Assumes: All inputs synchronous to clk_sys_i; rst_n_i is the power-on reset
// Notes:   RC oscillator rate is modelled by an enable divider off clk_sys_i
//          A timeout beats a refresh or a mode write in the same cycle
//          Status register shows running, window open and timeout cause
//          Mode writes landing with a recovery or timeout are lost on purpose
//
// How it works
// (R1) Retriggerable counter resets CPU at terminal count
// (R2) Idle until first refresh instruction starts it
// (R3) Later refreshes restart the count from zero
// (R4) Counter advances only on RC oscillator ticks
// (R5) Refresh instruction updates zero, sign, overflow flags
// (R6) Mode bits 1:0 pick the timeout tap
// (R7) Bit 2 counts in HALT, bit 3 in Stop
// (R8) Upper four mode bits have no effect
// (R9) Writes accepted only 60 cycles after first instruction
// (R10) After window, mode writes ignored until reset
// (R11) Mode register reads back as zero
// (R12) Mode register decoded at bank F, 0Fh
// (R13) Timeout holds CPU reset for 2.5 ms
// (R14) Watchdog reset restarts execution at 000Ch
// (R15) Four taps, larger code gives longer timeout
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
module wdtml_watchdog #(
  parameter int WDT_W      = 16,                   // Watchdog counter width
  parameter int RC_DIV     = 20,                   // System clocks per RC tick
  parameter int POR_CYCLES = wdtml_pkg::POR_CYCLES // Reset one-shot length
) (
  input  wire logic        clk_sys_i,              // System clock
  input  wire logic        rst_n_i,                // Power-on reset, active low
  input  wire logic        refresh_i,              // Refresh instruction executes
  input  wire logic        first_instr_i,          // First instruction after reset
  input  wire logic        cpu_cycle_i,            // One pulse per processor cycle
  input  wire logic        halt_i,                 // CPU in HALT
  input  wire logic        stop_i,                 // CPU in Stop
  input  wire logic        stop_recovery_i,        // stop_mode_recovery event
  input  wire logic [3:0]  reg_bank_i,             // Expanded register bank
  input  wire logic [7:0]  reg_addr_i,             // Register address
  input  wire logic [7:0]  reg_wdata_i,            // Write data
  input  wire logic        reg_we_i,               // Write strobe
  input  wire logic        reg_re_i,               // Read strobe
  output logic      [7:0]  reg_rdata_o,            // Read data, one cycle later
  output logic             flags_we_o,             // Flag update strobe
  output logic             flag_z_o,               // Zero flag value
  output logic             flag_s_o,               // Sign flag value
  output logic             flag_v_o,               // Overflow flag value
  output logic             cpu_reset_o,            // Hold CPU in reset
  output logic      [15:0] restart_addr_o,         // Fetch address after reset
  output logic             wdt_running_o           // Watchdog started by a refresh
);

  localparam int RCD_W = $clog2(RC_DIV + 1);       // RC divider width
  localparam int POR_W = $clog2(POR_CYCLES + 1);   // One-shot counter width

  logic [RCD_W-1:0]      rc_div_reg;               // RC tick divider
  logic                  rc_tick;                  // RC oscillator enable pulse
  logic [WDT_W-1:0]      wdt_cnt_reg;              // Watchdog count
  logic                  wdt_run_reg;              // Watchdog started
  logic                  timeout;                  // Terminal count reached
  logic                  count_en;                 // Counting allowed now
  logic [3:0]            mode_reg;                 // Stored mode bits
  wdtml_pkg::wdtml_win_type win_reg;               // Write window state
  logic [5:0]            win_cnt_reg;              // Processor cycles in window
  logic [POR_W-1:0]      por_cnt_reg;              // Reset one-shot count
  logic                  wdr_flag_reg;             // Last reset was a timeout
  logic                  refresh_ok;               // Refresh while CPU runs
  logic                  hit_mode;                 // Address selects mode reg
  logic                  hit_status;               // Address selects status reg
  logic                  mode_wr;                  // Accepted mode write
  logic                  win_restart;              // Qualifying reset event

  // Address decode inside the expanded bank
  assign hit_mode   = (reg_bank_i == wdtml_pkg::BANK_WDT)
                   && (reg_addr_i == wdtml_pkg::ADDR_MODE);     // R12
  assign hit_status = (reg_bank_i == wdtml_pkg::BANK_WDT)
                   && (reg_addr_i == wdtml_pkg::ADDR_STATUS);
  assign refresh_ok = refresh_i && !cpu_reset_o;
  assign win_restart = timeout || stop_recovery_i;

  // RC oscillator stand-in: one enable pulse every RC_DIV clocks
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rc_div_reg <= '0;
    else if (rc_div_reg == RCD_W'(RC_DIV - 1))
      rc_div_reg <= '0;
    else
      rc_div_reg <= rc_div_reg + RCD_W'(1);
  end
  assign rc_tick = (rc_div_reg == RCD_W'(RC_DIV - 1));

  // Counting gated by HALT and Stop options
  always_comb
  begin
    count_en = wdt_run_reg && rc_tick;                           // R4
    if (halt_i && !mode_reg[wdtml_pkg::MODE_HALT_BIT])
      count_en = 1'b0;                                           // R7
    if (stop_i && !mode_reg[wdtml_pkg::MODE_STOP_BIT])
      count_en = 1'b0;                                           // R7
  end

  // Terminal count at the selected tap
  assign timeout = wdt_run_reg
    && wdt_cnt_reg[wdtml_pkg::tap_index(mode_reg[1:0])];        // R6 R15

  // Watchdog run state: idle until the first refresh
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wdt_run_reg <= 1'b0;
    else if (timeout || stop_recovery_i)
      wdt_run_reg <= 1'b0;                                       // R1
    else if (refresh_ok)
      wdt_run_reg <= 1'b1;                                       // R2
  end

  // Watchdog count
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wdt_cnt_reg <= '0;
    else if (timeout || stop_recovery_i || refresh_ok)
      wdt_cnt_reg <= '0;                                         // R3
    else if (count_en)
      wdt_cnt_reg <= wdt_cnt_reg + WDT_W'(1);                    // R1
  end

  // Flag update from the refresh instruction
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      flags_we_o <= 1'b0;
      flag_z_o   <= 1'b0;
      flag_s_o   <= 1'b0;
      flag_v_o   <= 1'b0;
    end
    else
    begin
      flags_we_o <= refresh_ok;                                  // R5
      if (refresh_ok)
      begin
        flag_z_o <= wdtml_pkg::FLAG_Z_VAL;                       // R5
        flag_s_o <= wdtml_pkg::FLAG_S_VAL;                       // R5
        flag_v_o <= wdtml_pkg::FLAG_V_VAL;                       // R5
      end
    end
  end

  // Reset one-shot: runs at power-on and after each timeout
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      por_cnt_reg <= POR_W'(POR_CYCLES);
    else if (timeout)
      por_cnt_reg <= POR_W'(POR_CYCLES);                         // R13
    else if (por_cnt_reg != '0)
      por_cnt_reg <= por_cnt_reg - POR_W'(1);
  end
  assign cpu_reset_o = (por_cnt_reg != '0);                      // R13

  // Restart address and reset cause
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      restart_addr_o <= wdtml_pkg::RESTART_VECTOR;
      wdr_flag_reg   <= 1'b0;
    end
    else if (timeout)
    begin
      restart_addr_o <= wdtml_pkg::RESTART_VECTOR;               // R14
      wdr_flag_reg   <= 1'b1;
    end
    else if (stop_recovery_i)
      wdr_flag_reg   <= 1'b0;
  end

  // Write window state machine
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      win_reg     <= wdtml_pkg::WIN_WAIT;
      win_cnt_reg <= '0;
    end
    else if (win_restart)
    begin
      win_reg     <= wdtml_pkg::WIN_WAIT;                        // R10
      win_cnt_reg <= '0;
    end
    else
    begin
      case (win_reg)
        wdtml_pkg::WIN_WAIT:
        begin
          if (first_instr_i && !cpu_reset_o)
            win_reg <= wdtml_pkg::WIN_OPEN;                      // R9
        end
        wdtml_pkg::WIN_OPEN:
        begin
          if (cpu_cycle_i)
          begin
            if (win_cnt_reg == 6'(wdtml_pkg::WIN_CPU_CYCLES - 1))
              win_reg <= wdtml_pkg::WIN_LOCK;                    // R9
            win_cnt_reg <= win_cnt_reg + 6'h01;
          end
        end
        wdtml_pkg::WIN_LOCK:
          win_reg <= wdtml_pkg::WIN_LOCK;                        // R10
        default:
          win_reg <= wdtml_pkg::WIN_LOCK;
      endcase
    end
  end

  // Mode register: low nibble stored, upper nibble dropped
  assign mode_wr = reg_we_i && hit_mode && (win_reg == wdtml_pkg::WIN_OPEN);
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mode_reg <= wdtml_pkg::MODE_RST;
    else if (win_restart)
      mode_reg <= wdtml_pkg::MODE_RST;
    else if (mode_wr)
      mode_reg <= reg_wdata_i[wdtml_pkg::MODE_WIDTH-1:0];        // R8 R9
  end

  // Read data: mode reads zero, status shows block state
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 8'h00;
    else if (reg_re_i && hit_status)
    begin
      reg_rdata_o <= 8'h00;
      reg_rdata_o[wdtml_pkg::STAT_RUN_BIT] <= wdt_run_reg;
      reg_rdata_o[wdtml_pkg::STAT_WIN_BIT] <= (win_reg == wdtml_pkg::WIN_OPEN);
      reg_rdata_o[wdtml_pkg::STAT_WDR_BIT] <= wdr_flag_reg;
    end
    else
      reg_rdata_o <= 8'h00;                                      // R11
  end

  assign wdt_running_o = wdt_run_reg;

  // Checks share the system clock
  // and are switched off while reset is low
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // Helper: cycles the CPU reset has been held so far
  int unsigned por_len;                                          // Reset hold length
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      por_len <= 0;
    else if (cpu_reset_o)
      por_len <= por_len + 1;
    else
      por_len <= 0;
  end

  // Counter, start and timeout
  chk_timeout_resets_cpu: assert property (timeout |=> cpu_reset_o && !wdt_run_reg) // R1
    else $error("Timeout did not reset the CPU");
  chk_idle_no_count: assert property (!wdt_run_reg && !refresh_ok |=> wdt_cnt_reg == '0) // R2
    else $error("Idle watchdog counted");
  chk_refresh_restarts: assert property (refresh_ok |=> wdt_run_reg && wdt_cnt_reg == '0) // R3
    else $error("Refresh did not restart the count");
  chk_count_on_tick: assert property ( // R4
      wdt_cnt_reg != $past(wdt_cnt_reg) && wdt_cnt_reg != '0 |-> $past(rc_tick))
    else $error("Count moved without an RC tick");
  chk_tap_terminal: assert property ( // R6 R15
      timeout && mode_reg[1:0] == 2'h3 |-> wdt_cnt_reg[wdtml_pkg::TAP2:0] == '0)
    else $error("Longest tap fired early");
  chk_tap_exact: assert property (timeout // R6 R15
      |-> wdt_cnt_reg == (WDT_W'(1) << wdtml_pkg::tap_index(mode_reg[1:0])))
    else $error("Timeout not at the selected tap");
  chk_halt_freeze: assert property (wdt_run_reg && halt_i // R7
      && !mode_reg[wdtml_pkg::MODE_HALT_BIT]
      && !refresh_ok && !timeout && !stop_recovery_i |=> $stable(wdt_cnt_reg))
    else $error("Count moved in HALT while disabled");
  chk_halt_counts: assert property (wdt_run_reg && rc_tick && halt_i && !stop_i // R7
      && mode_reg[wdtml_pkg::MODE_HALT_BIT] && !refresh_ok && !timeout && !stop_recovery_i
      |=> wdt_cnt_reg == $past(wdt_cnt_reg) + WDT_W'(1))
    else $error("Count stalled in HALT while enabled");
  chk_stop_freeze: assert property (wdt_run_reg && stop_i // R7
      && !mode_reg[wdtml_pkg::MODE_STOP_BIT]
      && !refresh_ok && !timeout && !stop_recovery_i |=> $stable(wdt_cnt_reg))
    else $error("Count moved in Stop while disabled");

  // Flags and mode field
  chk_flags_follow: assert property (refresh_ok |=> flags_we_o // R5
      && flag_z_o == wdtml_pkg::FLAG_Z_VAL
      && flag_s_o == wdtml_pkg::FLAG_S_VAL && flag_v_o == wdtml_pkg::FLAG_V_VAL)
    else $error("Flags not updated by refresh");
  chk_open_write: assert property (mode_wr && !win_restart // R8 R9 R12
      |=> mode_reg == $past(reg_wdata_i[3:0]))
    else $error("Window write not stored");

  // Write window
  chk_lock_ignore: assert property (win_reg == wdtml_pkg::WIN_LOCK // R10
      && !win_restart |=> $stable(mode_reg))
    else $error("Locked mode register changed");
  chk_window_length: assert property (win_reg == wdtml_pkg::WIN_OPEN // R9
      && win_cnt_reg == 6'(wdtml_pkg::WIN_CPU_CYCLES - 1)
      && cpu_cycle_i && !win_restart |=> win_reg == wdtml_pkg::WIN_LOCK)
    else $error("Window did not close after 60 cycles");
  chk_window_opens: assert property (win_reg == wdtml_pkg::WIN_WAIT && first_instr_i // R9
      && !cpu_reset_o && !win_restart |=> win_reg == wdtml_pkg::WIN_OPEN)
    else $error("Window did not open on the first instruction");
  chk_restart_clears: assert property (win_restart // R10
      |=> win_reg == wdtml_pkg::WIN_WAIT && mode_reg == wdtml_pkg::MODE_RST && !wdt_run_reg)
    else $error("Reset event did not clear mode and window");

  // Read port
  chk_mode_unreadable: assert property (reg_re_i && hit_mode |=> reg_rdata_o == 8'h00) // R11
    else $error("Mode register read back");
  chk_rdata_idle: assert property (!reg_re_i |=> reg_rdata_o == 8'h00) // R11
    else $error("Read data without a read strobe");

  // Reset one-shot and restart
  chk_por_length: assert property ($fell(cpu_reset_o) |-> $past(por_len) >= POR_CYCLES - 1) // R13
    else $error("CPU reset released too early");
  chk_por_reload: assert property (timeout |=> por_cnt_reg == POR_W'(POR_CYCLES)) // R13
    else $error("Timeout did not start the reset one-shot");
  chk_reset_refused: assert property (cpu_reset_o |=> !flags_we_o && !wdt_run_reg) // R2 R5
    else $error("Refresh taken while the CPU is held in reset");
  chk_restart_vector: assert property (cpu_reset_o // R14
      |-> restart_addr_o == wdtml_pkg::RESTART_VECTOR)
    else $error("Wrong restart address");
  chk_cause_flag: assert property (timeout |=> wdr_flag_reg) // R1
    else $error("Timeout cause not recorded");

  // Scenario covers
  cov_first_start: cover property (!wdt_run_reg ##1 wdt_run_reg);
  cov_timeout: cover property (timeout);
  cov_locked_write: cover property (win_reg == wdtml_pkg::WIN_LOCK && reg_we_i && hit_mode);
  cov_window_write: cover property (mode_wr);
  cov_halt_counting: cover property (halt_i && count_en);

endmodule

// ===== wdtml_core_model.sv
// Purpose: Processor core model driving refresh, first fetch and cycle pulses
// Assumes: One processor cycle is two system clocks
// Notes:   A refresh goes out one clock after the bench asks for it
`timescale 1ns/100ps
module wdtml_core_model (
  input  wire logic clk_sys_i,       // System clock
  input  wire logic rst_n_i,         // Power-on reset, active low
  input  wire logic cpu_reset_i,     // Core held in reset
  input  wire logic stop_recovery_i, // Recovery event
  input  wire logic sleep_i,         // HALT or Stop, core clock off
  input  wire logic refresh_req_i,   // Bench asks for a refresh
  output logic      refresh_o,       // Refresh instruction executes
  output logic      first_instr_o,   // First instruction after reset
  output logic      cpu_cycle_o      // One pulse per processor cycle
);
  logic boot_reg; // Core still waiting for its first fetch

  // Cycle pulses only while the core clock runs
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
      cpu_cycle_o <= 1'b0;
    else
      cpu_cycle_o <= !cpu_cycle_o && !cpu_reset_i && !sleep_i;

  // First fetch once reset or recovery has ended
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      boot_reg      <= 1'b1;
      first_instr_o <= 1'b0;
    end
    else
    begin
      boot_reg      <= cpu_reset_i || stop_recovery_i;
      first_instr_o <= boot_reg && !cpu_reset_i && !stop_recovery_i;
    end

  // Refresh instruction; a core in reset executes nothing
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
      refresh_o <= 1'b0;
    else
      refresh_o <= refresh_req_i && !cpu_reset_i;
endmodule

// ===== wdtml_watchdog_tb.sv
// Purpose: Self-checking bench for the watchdog with locked mode register
// Assumes: Shortened reset one-shot and RC divider
// Notes:   Mode padding and refresh spacing come from an xorshift generator
`timescale 1ns/100ps
module wdtml_watchdog_tb;
  localparam int POR = 20;           // One-shot length in clocks
  localparam int RC  = 2;            // System clocks per RC tick
  logic        clk_sys_i = 1'b0;     // System clock
  logic        rst_n_i = 1'b0;       // Reset, active low
  logic        refresh_req = 1'b0;   // Refresh request to the core
  logic        halt_i = 1'b0;        // HALT level
  logic        stop_i = 1'b0;        // Stop level
  logic        stop_recovery_i = 1'b0; // Recovery pulse
  logic        refresh_i;            // From core model
  logic        first_instr_i;        // From core model
  logic        cpu_cycle_i;          // From core model
  logic [3:0]  reg_bank_i = 4'h0;    // Register bank
  logic [7:0]  reg_addr_i = 8'h00;   // Register address
  logic [7:0]  reg_wdata_i = 8'h00;  // Write data
  logic        reg_we_i = 1'b0;      // Write strobe
  logic        reg_re_i = 1'b0;      // Read strobe
  logic [7:0]  reg_rdata_o;          // Read data
  logic        flags_we_o, flag_z_o, flag_s_o, flag_v_o; // Flag port
  logic        cpu_reset_o;          // CPU reset
  logic        wdt_running_o;        // Watchdog running
  logic [15:0] restart_addr_o;       // Restart address
  logic [31:0] seed = 32'h0000003e;  // Generator state
  logic [31:0] r;                    // Latest random word
  int          fails = 0;            // Mismatches
  int          check_count = 0;      // Comparisons
  int          n;                    // Cycle counter
  int          k;                    // Loop index

  // Free-running system clock
  always #2.5 clk_sys_i = ~clk_sys_i;

  wdtml_watchdog #(.WDT_W(16), .RC_DIV(RC), .POR_CYCLES(POR)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .refresh_i(refresh_i),
    .first_instr_i(first_instr_i), .cpu_cycle_i(cpu_cycle_i), .halt_i(halt_i),
    .stop_i(stop_i), .stop_recovery_i(stop_recovery_i), .reg_bank_i(reg_bank_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .flags_we_o(flags_we_o),
    .flag_z_o(flag_z_o), .flag_s_o(flag_s_o), .flag_v_o(flag_v_o),
    .cpu_reset_o(cpu_reset_o), .restart_addr_o(restart_addr_o),
    .wdt_running_o(wdt_running_o));

  wdtml_core_model core_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cpu_reset_i(cpu_reset_o),
    .stop_recovery_i(stop_recovery_i), .sleep_i(halt_i | stop_i),
    .refresh_req_i(refresh_req), .refresh_o(refresh_i),
    .first_instr_o(first_instr_i), .cpu_cycle_o(cpu_cycle_i));

  // Verdict and end of run
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Value compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string w);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s: got %h, expected %h", $time, w, got, exp);
    end
  endtask

  // Xorshift step
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected timeout in clocks for a select code
  function automatic int tmo(input int c);
    int t;
    case (c)
      0:       t = wdtml_pkg::TAP0;
      1:       t = wdtml_pkg::TAP1;
      2:       t = wdtml_pkg::TAP2;
      default: t = wdtml_pkg::TAP3;
    endcase
    return (1 << t) * RC;
  endfunction

  // Clock edges, then settle
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys_i);
    #1;
  endtask

  // One-cycle register write
  task automatic wr(input logic [3:0] b, input logic [7:0] a, input logic [7:0] d);
    reg_bank_i  <= b;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_we_i    <= 1'b1;
    tick(1);
    reg_we_i    <= 1'b0;
    tick(1);
  endtask

  // One-cycle read, data looked at in the next cycle only
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string w);
    reg_bank_i <= wdtml_pkg::BANK_WDT;
    reg_addr_i <= a;
    reg_re_i   <= 1'b1;
    tick(1);
    reg_re_i   <= 1'b0;
    chk({8'h00, reg_rdata_o}, {8'h00, e}, w);
    tick(1);
  endtask

  // Count clocks until reset falls; a hang ends the run
  task automatic wait_low();
    n = 0;
    while (cpu_reset_o !== 1'b0 && n < 200)
    begin
      tick(1);
      n++;
    end
    if (n >= 200)
    begin
      fails++;
      end_of_test();
    end
  endtask

  // Count clocks until reset rises, up to a limit
  task automatic run(input int lim);
    n = 0;
    while (cpu_reset_o !== 1'b1 && n < lim)
    begin
      tick(1);
      n++;
    end
  endtask

  // Refresh through the core, then its flag answer
  task automatic refresh();
    refresh_req <= 1'b1;
    tick(1);
    refresh_req <= 1'b0;
    tick(1);
    chk({flags_we_o, wdt_running_o, flag_z_o, flag_s_o, flag_v_o}, 16'h0018, "refresh");
  endtask

  // Timeout of a code, then one-shot, vector and status
  task automatic timed(input int c);
    run(tmo(c) + RC + 5);
    halt_i <= 1'b0;
    stop_i <= 1'b0;
    chk(cpu_reset_o === 1'b1 && n >= tmo(c) - RC - 2, 1'b1, "timeout");
    // Missing timeout: mismatch already counted, stop here
    if (cpu_reset_o !== 1'b1)
      end_of_test();
    wait_low();
    chk(n >= POR - 1 && n <= POR + 2, 1'b1, "one-shot");
    chk(restart_addr_o, wdtml_pkg::RESTART_VECTOR, "vector");
    tick(3);
    rd(wdtml_pkg::ADDR_STATUS, 8'h06, "after timeout");
  endtask

  // Recovery pulse
  task automatic recover();
    stop_recovery_i <= 1'b1;
    tick(1);
    stop_recovery_i <= 1'b0;
    tick(3);
  endtask

  // Main sequence
  initial
  begin
    tick(10);
    rst_n_i <= 1'b1;
    tick(1);
    wait_low();
    chk(n >= POR - 1 && n <= POR + 2, 1'b1, "power-on");
    chk(restart_addr_o, wdtml_pkg::RESTART_VECTOR, "vector");
    tick(3);
    rd(wdtml_pkg::ADDR_STATUS, 8'h02, "window open");
    r = rnd();
    wr(wdtml_pkg::BANK_WDT, wdtml_pkg::ADDR_MODE, {r[7:4], 4'h0});
    wr(4'he, wdtml_pkg::ADDR_MODE, 8'h03);
    wr(wdtml_pkg::BANK_WDT, 8'h0e, 8'h03);
    rd(wdtml_pkg::ADDR_MODE, 8'h00, "mode read");
    rd(8'h3c, 8'h00, "unmapped");
    run(2500);
    chk({cpu_reset_o, wdt_running_o}, 16'h0000, "idle");
    refresh();
    for (k = 0; k < 4; k++)
    begin
      r = rnd();
      tick(700 + r[6:0]);
      refresh();
    end
    chk(cpu_reset_o, 1'b0, "kept alive");
    timed(0);
    // Longer codes, random padding above the select field
    for (k = 1; k < 4; k++)
    begin
      r = rnd();
      wr(wdtml_pkg::BANK_WDT, wdtml_pkg::ADDR_MODE, {r[7:4], 2'b00, k[1:0]});
      refresh();
      if (k < 3)
        timed(k);
    end
    run(tmo(2) * 2);
    chk(cpu_reset_o, 1'b0, "longest code");
    recover();
    rd(wdtml_pkg::ADDR_STATUS, 8'h02, "recovered");
    tick(100);
    rd(wdtml_pkg::ADDR_STATUS, 8'h02, "window late");
    tick(20);
    rd(wdtml_pkg::ADDR_STATUS, 8'h00, "window shut");
    wr(wdtml_pkg::BANK_WDT, wdtml_pkg::ADDR_MODE, 8'h02);
    refresh();
    timed(0);
    // HALT and Stop, counting on and off
    for (k = 0; k < 4; k++)
    begin
      wr(wdtml_pkg::BANK_WDT, wdtml_pkg::ADDR_MODE, 8'(k[0]) << (2 + k[1]));
      refresh();
      if (k[1])
        stop_i <= 1'b1;
      else
        halt_i <= 1'b1;
      if (k[0])
        timed(0);
      else
      begin
        run(2500);
        chk(cpu_reset_o, 1'b0, "frozen");
        halt_i <= 1'b0;
        stop_i <= 1'b0;
        recover();
      end
    end
    end_of_test();
  end
endmodule
